/* File: common/sppc_pkg.sv */
package sppc_pkg;
  // pointer and data geometry
  localparam int SPPC_ADDR_W = 13;
  localparam int SPPC_DATA_W = 16;
  localparam int SPPC_FIFO_DEPTH = 16;
  // reset values
  localparam logic [SPPC_ADDR_W-1:0] SPPC_ADDR_RST = 13'h0000;
  // command-mode restart register
  localparam logic [2:0] SPPC_CMD_RESTART_ADDR = 3'h4;
  localparam int SPPC_CMD_RELEASE_BIT = 4;

  typedef enum logic [1:0] {
    SPPC_LOAD_NONE,
    SPPC_LOAD_EXT,
    SPPC_LOAD_START
  } sppc_load_t;

  // sequential-side control group
  typedef struct packed {
    logic pointer_load_n;
    logic start_pointer_one_load_n;
    logic start_pointer_two_load_n;
    logic counter_advance_n;
    logic seq_chip_select_n;
    logic seq_read_write_sel;
    logic seq_output_enable_n;
  } sppc_seq_ctl_t;

  // random-side command access
  typedef struct packed {
    logic cmd_select_n;
    logic rand_chip_enable_n;
    logic write_n;
    logic [2:0] addr;
    logic [SPPC_DATA_W-1:0] data;
  } sppc_cmd_t;
endpackage : sppc_pkg

/* File: logic/sppc_fifo.sv */
`timescale 1ns/100ps
module sppc_fifo
  import sppc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // handshakes
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= AW'((wr_ptr_ff + 1'b1) % DEPTH);
      end
      if (pop)
      begin
        rd_ptr_ff <= AW'((rd_ptr_ff + 1'b1) % DEPTH);
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sppc_fifo

/* File: logic/sppc_core.sv */
`timescale 1ns/100ps
// Overview of operation
// - any load input low loads the address
// - advance high holds the counter
// - no increment right after external load
// - start-pointer load does not suppress counting
// - read select drives addressed word out
// - write select stores word, even after read
// - write select disables outputs until read sampled
// - held counter rewrites the same location
// - reset forces write state, outputs off
// - after reset access starts at zero
// - command write of zero restarts stopped port
module sppc_core
  import sppc_pkg::*;
#(
  parameter int ADDR_W = SPPC_ADDR_W,
  parameter int DATA_W = SPPC_DATA_W,
  parameter int FIFO_DEPTH = SPPC_FIFO_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire sppc_seq_ctl_t seq_ctl,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [ADDR_W-1:0] start_ptr_one,
  input wire logic [ADDR_W-1:0] start_ptr_two,
  input wire logic [DATA_W-1:0] seq_data_in,
  input wire logic stop_request,
  input wire sppc_cmd_t cmd,
  output logic [DATA_W-1:0] seq_data_out,
  output logic seq_data_oe_n,
  output logic [ADDR_W-1:0] seq_addr,
  output logic stopped,
  output logic wr_ready,
  output logic [DATA_W-1:0] mem_wr_data,
  output logic [ADDR_W-1:0] mem_wr_addr,
  output logic mem_wr_en,
  output logic internal_counter_clear
);
  localparam int DEPTH = 1 << ADDR_W;

  // sequential-port state
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic hold_after_load_ff;
  logic read_state_ff;
  logic stopped_ff;
  logic clear_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic oe_n_ff;
  logic [DATA_W-1:0] mem_ff [DEPTH];
  sppc_load_t load_kind;
  logic access;
  logic is_write;
  logic advance;
  logic restart_cmd;

  // write-path buffer signals
  logic fifo_in_ready;
  logic [ADDR_W+DATA_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_wr_ready_ff;
  logic mem_wr_en_ff;
  logic [DATA_W-1:0] mem_wr_data_ff;
  logic [ADDR_W-1:0] mem_wr_addr_ff;

  // classify the load for this edge
  always_comb
  begin
    load_kind = SPPC_LOAD_NONE;
    if (!seq_ctl.pointer_load_n)
    begin
      load_kind = SPPC_LOAD_EXT;
    end
    else if (!seq_ctl.start_pointer_one_load_n || !seq_ctl.start_pointer_two_load_n)
    begin
      load_kind = SPPC_LOAD_START;
    end
  end

  // random-side restart command decode
  assign restart_cmd = !cmd.cmd_select_n && cmd.rand_chip_enable_n && !cmd.write_n &&
                       (cmd.addr == SPPC_CMD_RESTART_ADDR) &&
                       !cmd.data[SPPC_CMD_RELEASE_BIT];

  assign access = !seq_ctl.seq_chip_select_n && !stopped_ff;
  assign is_write = access && !seq_ctl.seq_read_write_sel;
  // count only when enabled, not right after external load
  assign advance = !seq_ctl.counter_advance_n && !hold_after_load_ff &&
                   !stopped_ff;

  // next pointer value
  always_comb
  begin
    nxt_addr = addr_ff;
    unique case (load_kind)
      SPPC_LOAD_EXT:
      begin
        nxt_addr = ext_addr;
      end
      SPPC_LOAD_START:
      begin
        nxt_addr = !seq_ctl.start_pointer_one_load_n ? start_ptr_one
                                                     : start_ptr_two;
      end
      SPPC_LOAD_NONE:
      begin
        if (advance)
        begin
          nxt_addr = addr_ff + 1'b1;
        end
      end
    endcase
  end

  // address counter and load-suppress flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clear_ff)
    begin
      addr_ff <= SPPC_ADDR_RST;
      hold_after_load_ff <= 1'b0;
    end
    else
    begin
      addr_ff <= nxt_addr;
      hold_after_load_ff <= (load_kind == SPPC_LOAD_EXT);
    end
  end

  // read/write state; reset forces write
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      read_state_ff <= 1'b0;
    end
    else if (!seq_ctl.seq_chip_select_n)
    begin
      read_state_ff <= seq_ctl.seq_read_write_sel;
    end
  end

  // stop mode and counter release
  // a stop request outranks a same-cycle restart, so no stop is lost
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      stopped_ff <= 1'b0;
      clear_ff <= 1'b0;
    end
    else
    begin
      clear_ff <= restart_cmd && stopped_ff && !stop_request;
      if (stop_request)
      begin
        stopped_ff <= 1'b1;
      end
      else if (restart_cmd)
      begin
        stopped_ff <= 1'b0;
      end
    end
  end

  // read data and output drive
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rd_data_ff <= '0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      if (access && seq_ctl.seq_read_write_sel)
      begin
        rd_data_ff <= mem_ff[addr_ff];
      end
      oe_n_ff <= seq_ctl.seq_output_enable_n || !read_state_ff ||
                 (!seq_ctl.seq_chip_select_n && !seq_ctl.seq_read_write_sel);
    end
  end

  // buffered write path into the array
  sppc_fifo #(
    .WIDTH(ADDR_W + DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_data({addr_ff, seq_data_in}),
    .in_valid(is_write),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1)
  );

  // array write from fifo head
  always_ff @(posedge ref_clk)
  begin
    if (fifo_out_valid)
    begin
      mem_ff[fifo_out[ADDR_W+DATA_W-1:DATA_W]] <= fifo_out[DATA_W-1:0];
    end
  end

  // write port mirror and ready
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      mem_wr_en_ff <= 1'b0;
      mem_wr_data_ff <= '0;
      mem_wr_addr_ff <= '0;
      fifo_wr_ready_ff <= 1'b0;
    end
    else
    begin
      mem_wr_en_ff <= fifo_out_valid;
      mem_wr_data_ff <= fifo_out[DATA_W-1:0];
      mem_wr_addr_ff <= fifo_out[ADDR_W+DATA_W-1:DATA_W];
      fifo_wr_ready_ff <= fifo_in_ready;
    end
  end

  // outputs, each straight from a register
  assign seq_data_out = rd_data_ff;
  assign seq_data_oe_n = oe_n_ff;
  assign seq_addr = addr_ff;
  assign stopped = stopped_ff;
  assign wr_ready = fifo_wr_ready_ff;
  assign mem_wr_data = mem_wr_data_ff;
  assign mem_wr_addr = mem_wr_addr_ff;
  assign mem_wr_en = mem_wr_en_ff;
  assign internal_counter_clear = clear_ff;

  // checks
  a_ext_load_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !seq_ctl.pointer_load_n && !clear_ff ##1 !clear_ff |-> addr_ff == $past(ext_addr))
    else $error("external load missed");
  a_start_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    load_kind == SPPC_LOAD_START && !clear_ff |=>
    addr_ff == $past(seq_ctl.start_pointer_one_load_n ? start_ptr_two : start_ptr_one))
    else $error("start pointer load missed");
  a_hold_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
    load_kind == SPPC_LOAD_NONE && seq_ctl.counter_advance_n && !clear_ff |=> $stable(addr_ff))
    else $error("counter moved while held");
  a_no_inc_after: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !seq_ctl.pointer_load_n ##1 load_kind == SPPC_LOAD_NONE && !clear_ff |=> $stable(addr_ff))
    else $error("increment after external load");
  a_start_counts: assert property (@(posedge ref_clk) disable iff (!rst_b)
    load_kind == SPPC_LOAD_START ##1 (load_kind == SPPC_LOAD_NONE && advance && !clear_ff)
    |=> addr_ff == $past(addr_ff) + 1'b1)
    else $error("no count after start load");
  a_step_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
    load_kind == SPPC_LOAD_NONE && advance && !clear_ff |=> addr_ff == $past(addr_ff) + 1'b1)
    else $error("counter step not one");
  a_held_rewrite: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_write && seq_ctl.counter_advance_n && load_kind == SPPC_LOAD_NONE && !clear_ff
    ##1 is_write |-> addr_ff == $past(addr_ff))
    else $error("held write moved address");

  // port and output checks
  a_wr_disables: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !seq_ctl.seq_chip_select_n && !seq_ctl.seq_read_write_sel |=> oe_n_ff)
    else $error("output on during write");
  a_read_drives: assert property (@(posedge ref_clk) disable iff (!rst_b)
    read_state_ff && !seq_ctl.seq_output_enable_n && !seq_ctl.seq_chip_select_n &&
    seq_ctl.seq_read_write_sel |=> !oe_n_ff)
    else $error("read output not driven");
  a_write_queued: assert property (@(posedge ref_clk) disable iff (!rst_b)
    is_write && fifo_in_ready |=> ##[0:16] mem_wr_en_ff)
    else $error("write not stored");
  a_reset_write: assert property (@(posedge ref_clk)
    !rst_b |=> oe_n_ff && !read_state_ff)
    else $error("reset left outputs on");
  a_reset_zero: assert property (@(posedge ref_clk)
    !rst_b |=> addr_ff == SPPC_ADDR_RST)
    else $error("reset address not zero");

  // stop and restart checks
  a_restart_clr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    restart_cmd && stopped_ff && !stop_request |=>
    !stopped_ff && clear_ff ##1 addr_ff == SPPC_ADDR_RST)
    else $error("restart failed");
  a_stop_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stopped_ff && load_kind == SPPC_LOAD_NONE && !clear_ff |=> $stable(addr_ff))
    else $error("counter moved while stopped");
  a_clear_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clear_ff |=> !clear_ff)
    else $error("counter clear longer than one cycle");

  // main-scenario covers
  c_burst_read: cover property (@(posedge ref_clk) disable iff (!rst_b)
    access && seq_ctl.seq_read_write_sel && advance [*3]);
  c_wr_after_rd: cover property (@(posedge ref_clk) disable iff (!rst_b)
    access && seq_ctl.seq_read_write_sel ##1 is_write);
  c_restart: cover property (@(posedge ref_clk) disable iff (!rst_b)
    stopped_ff ##1 restart_cmd);
  c_held_rewrite: cover property (@(posedge ref_clk) disable iff (!rst_b)
    is_write && seq_ctl.counter_advance_n ##1 is_write);
endmodule : sppc_core

/* File: dv/sppc_rand_host.sv */
`timescale 1ns/100ps
module sppc_rand_host
  import sppc_pkg::*;
(
  input wire logic ref_clk,
  output sppc_cmd_t cmd
);
  // idle random side, both selects high, data bus parked
  initial cmd = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0010};
  // one-cycle command write with the release bit at zero
  task automatic restart();
    @(posedge ref_clk);
    #1;
    cmd = '{1'b0, 1'b1, 1'b0, SPPC_CMD_RESTART_ADDR, 16'hffef};
    @(posedge ref_clk);
    #1;
    cmd = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0010};
  endtask : restart
endmodule : sppc_rand_host

/* File: dv/test_sequential_port_pointer_control.sv */
`timescale 1ns/100ps
module test_sequential_port_pointer_control
  import sppc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  sppc_seq_ctl_t seq_ctl;
  sppc_seq_ctl_t c;
  sppc_seq_ctl_t idle = 7'h7f;
  sppc_cmd_t cmd;
  logic [SPPC_ADDR_W-1:0] ext_addr, sp1, sp2, seq_addr, mem_wr_addr, a;
  logic [SPPC_DATA_W-1:0] din, seq_data_out, mem_wr_data, d;
  logic stop_request, seq_data_oe_n, stopped, wr_ready, mem_wr_en, internal_counter_clear;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [28:0] wq[$];

  always #5 ref_clk = ~ref_clk;

  sppc_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .seq_ctl(seq_ctl), .ext_addr(ext_addr),
    .start_ptr_one(sp1), .start_ptr_two(sp2), .seq_data_in(din), .stop_request(stop_request),
    .cmd(cmd), .seq_data_out(seq_data_out), .seq_data_oe_n(seq_data_oe_n), .seq_addr(seq_addr),
    .stopped(stopped), .wr_ready(wr_ready), .mem_wr_data(mem_wr_data),
    .mem_wr_addr(mem_wr_addr), .mem_wr_en(mem_wr_en),
    .internal_counter_clear(internal_counter_clear));
  sppc_rand_host host (.ref_clk(ref_clk), .cmd(cmd));

  // compare and count
  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // drive one cycle, settle after the edge
  task automatic step(input sppc_seq_ctl_t s);
    seq_ctl = s;
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // array writes checked against oldest note, plus hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (mem_wr_en === 1'b1)
      chk({mem_wr_addr, mem_wr_data}, (wq.size() > 0) ? wq.pop_front() : '1);
    if (cycles == 3000)
    begin
      miscompares++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    seq_ctl = idle;
    ext_addr = '0;
    sp1 = '0;
    sp2 = '0;
    din = '0;
    stop_request = 1'b0;
    void'($urandom(32'he30f));
    repeat (8) @(posedge ref_clk);
    #1;
    chk(seq_data_oe_n, 1'b1);
    chk(seq_addr, SPPC_ADDR_RST);
    rst_b = 1'b1;
    // first writes land at 0 then 1
    c = idle;
    c.seq_chip_select_n = 1'b0;
    c.seq_read_write_sel = 1'b0;
    c.counter_advance_n = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      din = 16'($urandom);
      wq.push_back({13'(i), din});
      step(c);
    end
    chk(wr_ready, 1'b1);
    $display("test reset done");
    // external load, suppressed step, count, hold
    a = 13'($urandom_range(8000));
    ext_addr = a;
    c = idle;
    c.pointer_load_n = 1'b0;
    step(c);
    chk(seq_addr, a);
    c = idle;
    c.counter_advance_n = 1'b0;
    step(c);
    chk(seq_addr, a);
    step(c);
    chk(seq_addr, a + 13'h0001);
    step(idle);
    chk(seq_addr, a + 13'h0001);
    $display("test load done");
    // two writes to a held counter, outputs stay off
    c = idle;
    c.seq_chip_select_n = 1'b0;
    c.seq_read_write_sel = 1'b0;
    c.seq_output_enable_n = 1'b0;
    repeat (2)
    begin
      din = 16'($urandom);
      wq.push_back({a + 13'h0001, din});
      step(c);
      chk(seq_data_oe_n, 1'b1);
    end
    d = din;
    repeat (3) step(idle);
    c.seq_read_write_sel = 1'b1;
    step(c);
    step(c);
    chk(seq_data_out, d);
    chk(seq_data_oe_n, 1'b0);
    c.seq_read_write_sel = 1'b0;
    din = 16'($urandom);
    wq.push_back({a + 13'h0001, din});
    step(c);
    chk(seq_data_oe_n, 1'b1);
    $display("test access done");
    // both start pointers, counting not suppressed
    for (int i = 0; i < 2; i++)
    begin
      a = 13'($urandom_range(4000));
      sp1 = a;
      sp2 = a ^ 13'h1000;
      c = idle;
      c.counter_advance_n = 1'b0;
      if (i == 0)
        c.start_pointer_one_load_n = 1'b0;
      else
        c.start_pointer_two_load_n = 1'b0;
      step(c);
      chk(seq_addr, (i == 1) ? sp2 : sp1);
      c = idle;
      c.counter_advance_n = 1'b0;
      step(c);
      chk(seq_addr, ((i == 1) ? sp2 : sp1) + 13'h0001);
    end
    $display("test start pointer done");
    // stop, then restart from the command side
    stop_request = 1'b1;
    step(idle);
    stop_request = 1'b0;
    chk(stopped, 1'b1);
    // a write while stopped is refused and must not move the counter
    c = idle;
    c.seq_chip_select_n = 1'b0;
    c.seq_read_write_sel = 1'b0;
    c.counter_advance_n = 1'b0;
    step(c);
    step(idle);
    chk(seq_addr, sp2 + 13'h0001);
    host.restart();
    for (int n = 0; n < 4 && internal_counter_clear !== 1'b1; n++)
      step(idle);
    chk(internal_counter_clear, 1'b1);
    chk(stopped, 1'b0);
    step(idle);
    chk(seq_addr, SPPC_ADDR_RST);
    repeat (4) step(idle);
    chk(29'(wq.size()), 29'h0);
    $display("test restart done");
    conclude();
  end
endmodule : test_sequential_port_pointer_control
